// ### apc_defs.svh
/*
  register offsets, command encodings, field positions and timing counts
  of the axis position block. assumes inclusion by bare name.
*/
`ifndef APC_DEFS_SVH
`define APC_DEFS_SVH

// ----------------------------------------------------------------
// geometry
// ----------------------------------------------------------------
`define APC_NAXES 4
`define APC_AXW 2

// ----------------------------------------------------------------
// apb byte offsets
// ----------------------------------------------------------------
`define APC_ADDR_CMD 8'h00
`define APC_ADDR_DATA 8'h04
`define APC_ADDR_RB_LO 8'h08
`define APC_ADDR_RB_HI 8'h0c
`define APC_ADDR_STATUS 8'h10
`define APC_ADDR_IRQ_STS 8'h14
`define APC_ADDR_IRQ_MASK 8'h18
`define APC_ADDR_CFG 8'h1c

// ----------------------------------------------------------------
// command word layout and codes
// ----------------------------------------------------------------
`define APC_CMD_RESET 16'h8000
`define APC_CMD_CODE_MSB 3
`define APC_CMD_CODE_LSB 0
`define APC_CMD_AXIS_MSB 9
`define APC_CMD_AXIS_LSB 8
`define APC_OP_WR_CPOS 4'h1
`define APC_OP_WR_FPOS 4'h2
`define APC_OP_WR_CMPP 4'h3
`define APC_OP_WR_CMPM 4'h4
`define APC_OP_RD_CPOS 4'h5
`define APC_OP_RD_FPOS 4'h6
`define APC_OP_RD_SPEED 4'h7
`define APC_OP_RD_RATE 4'h8

// ----------------------------------------------------------------
// config fields: encoder mode, compare source, wrap mode (one bit per axis)
// ----------------------------------------------------------------
`define APC_CFG_ENC_LSB 0
`define APC_CFG_SRC_LSB 4
`define APC_CFG_WRAP_LSB 8
`define APC_CFG_W 12

// ----------------------------------------------------------------
// status word: compare source and wrap bits, limits, busy
// ----------------------------------------------------------------
`define APC_STS_CFG_LSB 0
`define APC_STS_LIMP_LSB 8
`define APC_STS_LIMN_LSB 12
`define APC_STS_BUSY_BIT 16

// ----------------------------------------------------------------
// interrupt status: limit+ per axis, limit- per axis, command done
// ----------------------------------------------------------------
`define APC_IRQ_W 9
`define APC_IRQ_LIMP_LSB 0
`define APC_IRQ_LIMN_LSB 4
`define APC_IRQ_DONE_BIT 8

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define APC_CLK_MHZ 125
`define APC_BUSY_MAX_NS 875
`define APC_BUSY_MAX_CYC ((`APC_BUSY_MAX_NS * `APC_CLK_MHZ) / 1000)
`define APC_BUSY_HOLD_CYC 8'h04
`define APC_SRST_HOLD_CYC 8'h10
`define APC_CNT_W 8

`endif

// ### apc_pkg.sv
/*
  types of the axis position block: busy sequencer states and the
  packed state record. assumes apc_defs.svh on the include path.
*/
`default_nettype none
`include "apc_defs.svh"

package apc_pkg;

  typedef enum logic [2:0] {
    APC_ST_IDLE = 3'b001,
    APC_ST_BUSY = 3'b010,
    APC_ST_SRST = 3'b100
  } apc_state_t;

  typedef logic [`APC_NAXES-1:0][31:0] apc_axis_word_t;

  typedef struct packed {
    apc_state_t st;
    logic [`APC_CNT_W-1:0] cnt;
    apc_axis_word_t cpos;
    apc_axis_word_t fpos;
    apc_axis_word_t cmpp;
    apc_axis_word_t cmpm;
    logic [`APC_NAXES-1:0][1:0] enc_prev;
    logic [31:0] data;
    logic [31:0] rb;
    logic [`APC_CFG_W-1:0] cfg;
    logic [`APC_IRQ_W-1:0] irq_sts;
    logic [`APC_IRQ_W-1:0] irq_mask;
    logic [`APC_NAXES-1:0] lim_p;
    logic [`APC_NAXES-1:0] lim_n;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic busy_n;
    logic irq;
    logic srst;
  } apc_regs_t;

endpackage

`default_nettype wire

// ### apc_top.sv
/*
  axis position counters, feedback decoding, compare limits, wrap mode,
  read-back latch and whole-block reset command, behind an apb slave.
  assumes step/direction pulses and speed/rate values come from the
  profile generator on the same 125 mhz clock, encoder inputs already
  synchronous to it. the host polls busy high before each command:
  a write that lands during the soft reset is lost, and a limit output
  trails the counter it watches by one cycle.
*/
`timescale 1ns/1ps
`default_nettype none
`include "apc_defs.svh"

module apc_top (
  input wire logic ref_clk_i, // 125 mhz clock
  input wire logic resetn_i, // async reset, active low
  input wire logic psel_i, // apb select
  input wire logic penable_i, // apb enable
  input wire logic pwrite_i, // apb direction
  input wire logic [7:0] paddr_i, // apb byte address
  input wire logic [31:0] pwdata_i, // apb write data
  output logic pready_o, // apb ready
  output logic [31:0] prdata_o, // apb read data
  output logic pslverr_o, // apb error, unmapped address
  input wire logic [`APC_NAXES-1:0] step_i, // one-cycle step pulse per axis
  input wire logic [`APC_NAXES-1:0] step_dir_i, // step direction, 1 = positive
  input wire logic [`APC_NAXES-1:0] enc_a_i, // encoder a or up input
  input wire logic [`APC_NAXES-1:0] enc_b_i, // encoder b or down input
  input wire logic [`APC_NAXES-1:0] moving_i, // axis is driving
  input wire logic [`APC_NAXES*32-1:0] speed_i, // present speed per axis
  input wire logic [`APC_NAXES*32-1:0] rate_i, // present rate change per axis
  output logic [`APC_NAXES-1:0] limit_pos_o, // positive travel limit reached
  output logic [`APC_NAXES-1:0] limit_neg_o, // negative travel limit reached
  output logic device_occupied_low_o, // busy, active low
  output logic ctrl_reset_o, // whole-block reset to sibling logic
  output logic irq_o // level interrupt
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // one count step with optional wrap between zero and mx
  function automatic logic [31:0] apc_step(input logic [31:0] v, input logic up, input logic dn,
                                           input logic wrap, input logic [31:0] mx);
    logic [31:0] r;
    r = v;
    if (up && !dn) begin
      if (wrap && (v == mx)) begin
        r = 32'h0000_0000;
      end else begin
        r = v + 32'h0000_0001;
      end
    end else if (dn && !up) begin
      if (wrap && (v == 32'h0000_0000)) begin
        r = mx;
      end else begin
        r = v - 32'h0000_0001;
      end
    end
    return r;
  endfunction

  // encoder decode: returns {up, dn}
  function automatic logic [1:0] apc_enc(input logic quad, input logic [1:0] prv, input logic a,
                                         input logic b);
    logic [1:0] r;
    logic one;
    r = 2'h0;
    one = (prv[1] ^ a) ^ (prv[0] ^ b);
    if (quad) begin
      // a leading b counts up; a double change is a glitch and is dropped
      r[1] = one & ~(prv[1] ^ b);
      r[0] = one & (prv[1] ^ b);
    end else begin
      r[1] = a & ~prv[1];
      r[0] = b & ~prv[0];
    end
    return r;
  endfunction

  function automatic logic [31:0] apc_slice(input logic [`APC_NAXES*32-1:0] v,
                                            input logic [`APC_AXW-1:0] ax);
    return v[ax*32 +: 32];
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  localparam apc_pkg::apc_regs_t RST = '{
    st: apc_pkg::APC_ST_IDLE,
    cnt: '0,
    cpos: '0,
    fpos: '0,
    cmpp: '0,
    cmpm: '0,
    enc_prev: '0,
    data: '0,
    rb: '0,
    cfg: '0,
    irq_sts: '0,
    irq_mask: '0,
    lim_p: '0,
    lim_n: '0,
    pready: 1'b0,
    pslverr: 1'b0,
    prdata: '0,
    busy_n: 1'b1,
    irq: 1'b0,
    srst: 1'b0
  };

  apc_pkg::apc_regs_t s_ff;
  apc_pkg::apc_regs_t nxt_s;

  logic acc;
  logic wr_done;
  logic [15:0] cmd;
  logic [3:0] op;
  logic [`APC_AXW-1:0] ax;
  logic [1:0] ud;
  logic [`APC_IRQ_W-1:0] ev;
  logic [31:0] src;
  logic wrap;
  apc_pkg::apc_regs_t keep_s;

  assign acc = psel_i & penable_i;
  assign wr_done = acc & s_ff.pready & pwrite_i;
  assign cmd = pwdata_i[15:0];
  assign op = cmd[`APC_CMD_CODE_MSB:`APC_CMD_CODE_LSB];
  assign ax = cmd[`APC_CMD_AXIS_MSB:`APC_CMD_AXIS_LSB];

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // later steps override earlier ones within a cycle: counting, apb
  // answer, completing writes, then the busy sequencer, whose soft
  // reset wins over all but the apb answer and encoder history, and last the interrupt status
  always_comb begin
    nxt_s = s_ff;
    ev = '0;
    ud = 2'h0;
    src = 32'h0000_0000;
    wrap = 1'b0;
    keep_s = s_ff;
    nxt_s.srst = 1'b0;

    // counting runs every cycle outside the soft reset, including during host accesses
    for (int i = 0; i < `APC_NAXES; i++) begin
      wrap = s_ff.cfg[`APC_CFG_WRAP_LSB + i];
      // comp+ carries the maximum in wrap mode
      nxt_s.cpos[i] = apc_step(s_ff.cpos[i], step_i[i] & step_dir_i[i], step_i[i] & ~step_dir_i[i],
                               wrap, s_ff.cmpp[i]);
      ud = apc_enc(s_ff.cfg[`APC_CFG_ENC_LSB + i], s_ff.enc_prev[i], enc_a_i[i], enc_b_i[i]);
      nxt_s.fpos[i] = apc_step(s_ff.fpos[i], ud[1], ud[0], wrap, s_ff.cmpp[i]);
      nxt_s.enc_prev[i] = {enc_a_i[i], enc_b_i[i]};
      src = s_ff.cfg[`APC_CFG_SRC_LSB + i] ? s_ff.fpos[i] : s_ff.cpos[i];
      // signed compare over the full range; limits are dead in wrap mode
      nxt_s.lim_p[i] = !wrap && ($signed(src) >= $signed(s_ff.cmpp[i]));
      nxt_s.lim_n[i] = !wrap && ($signed(src) <= $signed(s_ff.cmpm[i]));
      ev[`APC_IRQ_LIMP_LSB + i] = nxt_s.lim_p[i] & ~s_ff.lim_p[i];
      ev[`APC_IRQ_LIMN_LSB + i] = nxt_s.lim_n[i] & ~s_ff.lim_n[i];
    end

    // apb: one wait cycle so read data leaves a flip-flop
    nxt_s.pready = acc & ~s_ff.pready;
    if (acc && !s_ff.pready) begin
      nxt_s.pslverr = 1'b0;
      nxt_s.prdata = 32'h0000_0000;
      case (paddr_i)
        `APC_ADDR_CMD: nxt_s.prdata = 32'h0000_0000;
        `APC_ADDR_DATA: nxt_s.prdata = s_ff.data;
        `APC_ADDR_RB_LO: nxt_s.prdata = {16'h0000, s_ff.rb[15:0]};
        `APC_ADDR_RB_HI: nxt_s.prdata = {16'h0000, s_ff.rb[31:16]};
        `APC_ADDR_STATUS: begin
          nxt_s.prdata[`APC_STS_CFG_LSB +: 2*`APC_NAXES] = s_ff.cfg[`APC_CFG_W-1:`APC_CFG_SRC_LSB];
          nxt_s.prdata[`APC_STS_LIMP_LSB +: `APC_NAXES] = s_ff.lim_p;
          nxt_s.prdata[`APC_STS_LIMN_LSB +: `APC_NAXES] = s_ff.lim_n;
          nxt_s.prdata[`APC_STS_BUSY_BIT] = s_ff.busy_n;
        end
        `APC_ADDR_IRQ_STS: nxt_s.prdata = {23'h00_0000, s_ff.irq_sts};
        `APC_ADDR_IRQ_MASK: nxt_s.prdata = {23'h00_0000, s_ff.irq_mask};
        `APC_ADDR_CFG: nxt_s.prdata = {20'h0_0000, s_ff.cfg};
        default: nxt_s.pslverr = 1'b1;
      endcase
    end else begin
      // the error stands only with ready, never into the next cycle
      nxt_s.pslverr = 1'b0;
    end

    // writes take effect on the completing edge only
    if (wr_done) begin
      case (paddr_i)
        `APC_ADDR_DATA: nxt_s.data = pwdata_i;
        `APC_ADDR_IRQ_MASK: nxt_s.irq_mask = pwdata_i[`APC_IRQ_W-1:0];
        `APC_ADDR_CFG: nxt_s.cfg = pwdata_i[`APC_CFG_W-1:0];
        `APC_ADDR_CMD: begin
          if (cmd == `APC_CMD_RESET) begin
            nxt_s.st = apc_pkg::APC_ST_SRST;
            nxt_s.cnt = `APC_SRST_HOLD_CYC;
          end else begin
            case (op)
              // host writes override a count in the same cycle
              `APC_OP_WR_CPOS: nxt_s.cpos[ax] = s_ff.data;
              `APC_OP_WR_FPOS: nxt_s.fpos[ax] = s_ff.data;
              `APC_OP_WR_CMPP: nxt_s.cmpp[ax] = s_ff.data;
              `APC_OP_WR_CMPM: nxt_s.cmpm[ax] = s_ff.data;
              `APC_OP_RD_CPOS: nxt_s.rb = s_ff.cpos[ax];
              `APC_OP_RD_FPOS: nxt_s.rb = s_ff.fpos[ax];
              // stopped axis reads zero; sample is frozen until next request
              `APC_OP_RD_SPEED: nxt_s.rb = moving_i[ax] ? apc_slice(speed_i, ax) : 32'h0000_0000;
              `APC_OP_RD_RATE: nxt_s.rb = moving_i[ax] ? apc_slice(rate_i, ax) : 32'h0000_0000;
              default: nxt_s.rb = s_ff.rb;
            endcase
            nxt_s.st = apc_pkg::APC_ST_BUSY;
            nxt_s.cnt = `APC_BUSY_HOLD_CYC;
          end
          nxt_s.busy_n = 1'b0;
        end
        default: nxt_s.data = s_ff.data;
      endcase
    end

    // ----------------------------------------------------------------
    // busy sequencer
    // ----------------------------------------------------------------
    case (s_ff.st)
      apc_pkg::APC_ST_IDLE: nxt_s.busy_n = nxt_s.busy_n;
      apc_pkg::APC_ST_BUSY: begin
        // only a new command restarts the count; other writes do not stall it
        if (!(wr_done && (paddr_i == `APC_ADDR_CMD))) begin
          if (s_ff.cnt == '0) begin
            nxt_s.st = apc_pkg::APC_ST_IDLE;
            nxt_s.busy_n = 1'b1;
            ev[`APC_IRQ_DONE_BIT] = 1'b1;
          end else begin
            nxt_s.cnt = s_ff.cnt - 8'h01;
          end
        end
      end
      apc_pkg::APC_ST_SRST: begin
        // whole-block reset; apb handshake flops survive so the bus stays legal
        keep_s = nxt_s;
        nxt_s = RST;
        nxt_s.pready = keep_s.pready;
        nxt_s.prdata = keep_s.prdata;
        nxt_s.pslverr = keep_s.pslverr;
        // inputs stay tracked, so no false edge is counted when it ends
        nxt_s.enc_prev = keep_s.enc_prev;
        nxt_s.busy_n = 1'b0;
        nxt_s.srst = 1'b1;
        nxt_s.st = apc_pkg::APC_ST_SRST;
        nxt_s.cnt = s_ff.cnt - 8'h01;
        if (s_ff.cnt == '0) begin
          nxt_s.st = apc_pkg::APC_ST_IDLE;
          nxt_s.busy_n = 1'b1;
          nxt_s.srst = 1'b0;
          nxt_s.cnt = '0;
        end
      end
      default: nxt_s.st = apc_pkg::APC_ST_IDLE;
    endcase

    // ----------------------------------------------------------------
    // interrupts: set beats write-one-to-clear in the same cycle
    // ----------------------------------------------------------------
    if (s_ff.st != apc_pkg::APC_ST_SRST) begin
      if (wr_done && (paddr_i == `APC_ADDR_IRQ_STS)) begin
        nxt_s.irq_sts = s_ff.irq_sts & ~pwdata_i[`APC_IRQ_W-1:0];
      end
      nxt_s.irq_sts = nxt_s.irq_sts | ev;
    end
    nxt_s.irq = |(nxt_s.irq_sts & nxt_s.irq_mask);
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_ff <= RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all straight from the state record
  // ----------------------------------------------------------------
  assign pready_o = s_ff.pready;
  assign prdata_o = s_ff.prdata;
  assign pslverr_o = s_ff.pslverr;
  assign limit_pos_o = s_ff.lim_p;
  assign limit_neg_o = s_ff.lim_n;
  assign device_occupied_low_o = s_ff.busy_n;
  assign ctrl_reset_o = s_ff.srst;
  assign irq_o = s_ff.irq;

endmodule

`default_nettype wire

// ### apc_motion_model.sv
/*
  model of the profile generator and encoder that feed the position block.
  assumes one clock shared with the block, all outputs registered or derived from registers.
*/
`timescale 1ns/1ps
`default_nettype none
module apc_motion_model #(
  parameter logic [31:0] SPEED_RUN = 32'h0000_0100, // arbitrary speed while moving
  parameter logic [31:0] RATE_RUN = 32'h0000_0010 // arbitrary rate while moving
) (
  input wire logic clk_i, // clock
  input wire logic rst_n_i, // reset, active low
  input wire logic [3:0] run_i, // axis runs while high
  input wire logic [3:0] dir_i, // 1 = positive
  input wire logic [3:0] quad_i, // 1 = quadrature encoder
  output logic [3:0] step_o, // step pulse
  output logic [3:0] step_dir_o, // step direction
  output logic [3:0] enc_a_o, // encoder a or up
  output logic [3:0] enc_b_o, // encoder b or down
  output logic [3:0] moving_o, // axis driving
  output logic [127:0] speed_o, // speed per axis
  output logic [127:0] rate_o // rate per axis
);
  logic [3:0] tog;
  logic [3:0][1:0] ph;
  logic [31:0] junk;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tog <= 4'h0;
      ph <= 8'h00;
      junk <= 32'h5a5a_a5a5;
      step_o <= 4'h0;
      step_dir_o <= 4'h0;
      moving_o <= 4'h0;
    end else begin
      junk <= ~junk + 32'h0000_1357;
      for (int i = 0; i < 4; i++) begin
        // one step every other cycle so up/down pulses always have a rising edge
        tog[i] <= run_i[i] & ~tog[i];
        step_o[i] <= run_i[i] & ~tog[i];
        step_dir_o[i] <= dir_i[i];
        moving_o[i] <= run_i[i];
        if (run_i[i] & ~tog[i]) begin
          ph[i] <= dir_i[i] ? ph[i] + 2'h1 : ph[i] - 2'h1;
        end
      end
    end
  end
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      enc_a_o[i] = quad_i[i] ? ph[i][1] ^ ph[i][0] : step_o[i] & step_dir_o[i];
      enc_b_o[i] = quad_i[i] ? ph[i][1] : step_o[i] & ~step_dir_o[i];
      // stopped axes show a changing pattern, the block must gate it to zero
      speed_o[i*32 +: 32] = moving_o[i] ? SPEED_RUN + 32'(i) : junk;
      rate_o[i*32 +: 32] = moving_o[i] ? RATE_RUN + 32'(i) : ~junk;
    end
  end
endmodule
`default_nettype wire

// ### apc_top_properties.sv
/*
  assertions on the apb answer, busy and soft reset outputs of apc_top.
  assumes binding to apc_top, a single clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
`include "apc_defs.svh"
module apc_chk (
  input wire logic ref_clk_i, // clock
  input wire logic resetn_i, // reset, active low
  input wire logic psel_i, // apb select
  input wire logic penable_i, // apb enable
  input wire logic pwrite_i, // apb direction
  input wire logic [7:0] paddr_i, // apb address
  input wire logic [31:0] pwdata_i, // apb write data
  input wire logic pready_o, // apb ready
  input wire logic [31:0] prdata_o, // apb read data
  input wire logic pslverr_o, // apb error
  input wire logic device_occupied_low_o, // busy, active low
  input wire logic ctrl_reset_o // soft reset
);
  localparam int BUSY_MAX = `APC_BUSY_MAX_CYC;
  logic done_w;
  logic cmd_w;
  assign done_w = psel_i && penable_i && pready_o;
  assign cmd_w = done_w && pwrite_i && paddr_i == `APC_ADDR_CMD;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  AST_READY_PULSE: assert property (pready_o |=> !pready_o) else $error("ready held two cycles");
  AST_ONE_WAIT: assert property (psel_i && !penable_i |=> !pready_o ##1 pready_o) else $error("ready late");
  AST_ERR_WITH_READY: assert property (pslverr_o |-> pready_o) else $error("error without ready");
  AST_UNMAPPED_ERR: assert property (done_w && (paddr_i > `APC_ADDR_CFG || paddr_i[1:0] != 2'h0) |-> pslverr_o)
    else $error("unmapped ok");
  AST_MAPPED_OK: assert property (done_w && paddr_i <= `APC_ADDR_CFG && paddr_i[1:0] == 2'h0 |-> !pslverr_o)
    else $error("mapped error");
  AST_CMD_READ_ZERO: assert property (done_w && !pwrite_i && paddr_i == `APC_ADDR_CMD |-> prdata_o == 32'h0)
    else $error("command word read not zero");
  AST_BUSY_ANSWER: assert property (cmd_w && !ctrl_reset_o |-> ##[1:BUSY_MAX] !device_occupied_low_o)
    else $error("busy late");
  AST_SOFT_RESET: assert property (cmd_w && pwdata_i == 32'h0000_8000 |-> ##[1:2] ctrl_reset_o)
    else $error("soft reset missing");
  AST_NO_STRAY_RESET: assert property (cmd_w && pwdata_i[15:0] != `APC_CMD_RESET && !ctrl_reset_o
    |=> !ctrl_reset_o [*3]) else $error("stray soft reset");
  AST_RESET_HOLD: assert property ($rose(ctrl_reset_o) |-> ctrl_reset_o [*8])
    else $error("soft reset too short");
endmodule
bind apc_top apc_chk u_chk (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o), .prdata_o(prdata_o),
  .pslverr_o(pslverr_o), .device_occupied_low_o(device_occupied_low_o), .ctrl_reset_o(ctrl_reset_o));
`default_nettype wire

// ### testbench.sv
/*
  self-checking bench of apc_top: apb master tasks, motion model, read expectations in a queue.
  assumes apc_defs.svh on the include path and the checker bound by its own file.
*/
`timescale 1ns/1ps
`default_nettype none
`include "apc_defs.svh"
module testbench;
  localparam logic [31:0] SPD = 32'h0003_01f4;
  localparam logic [31:0] RAT = 32'h0002_0050;
  logic ref_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] run = 4'h0, dir = 4'h0, quad = 4'h0;
  logic pready, pslverr, busy_n, creset, irq;
  logic [31:0] prdata, v;
  logic [3:0] step, sdir, ea, eb, mov, lim_p, lim_n;
  logic [127:0] spd, rat;
  logic [31:0] tbl [4];
  logic [32:0] exp_q [$];
  int bad_count = 0;
  int samples_checked = 0;
  apc_top u_dut (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pready_o(pready), .prdata_o(prdata),
    .pslverr_o(pslverr), .step_i(step), .step_dir_i(sdir), .enc_a_i(ea), .enc_b_i(eb), .moving_i(mov),
    .speed_i(spd), .rate_i(rat), .limit_pos_o(lim_p), .limit_neg_o(lim_n), .device_occupied_low_o(busy_n),
    .ctrl_reset_o(creset), .irq_o(irq));
  apc_motion_model #(.SPEED_RUN(SPD), .RATE_RUN(RAT)) u_model (.clk_i(ref_clk_i), .rst_n_i(resetn_i),
    .run_i(run), .dir_i(dir), .quad_i(quad), .step_o(step), .step_dir_o(sdir), .enc_a_o(ea), .enc_b_o(eb),
    .moving_o(mov), .speed_o(spd), .rate_o(rat));
  initial begin
    forever #4 ref_clk_i = ~ref_clk_i;
  end
  // ----------------------------------------------------------------
  // checking and apb tasks
  // ----------------------------------------------------------------
  task automatic print_verdict;
    $display("checked %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic hang(input string what);
    bad_count++;
    $display("FAIL %s expected answer seen none", what);
    print_verdict();
  endtask
  // the oldest note is matched to each completed read
  always @(posedge ref_clk_i) begin
    if (psel && penable && !pwrite && pready === 1'b1) begin
      if (exp_q.size() == 0) check("unnoted read", {pslverr, prdata}, 33'h0);
      else check("read data", {pslverr, prdata}, exp_q.pop_front());
    end
  end
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk_i);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk_i);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) hang("apb ready");
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic cmd(input logic [3:0] op, input logic [1:0] ax);
    int n;
    apb(1'b1, `APC_ADDR_CMD, {22'h0, ax, 4'h0, op});
    n = 0;
    repeat (2) @(posedge ref_clk_i);
    while (busy_n !== 1'b1 && n < 200) begin
      @(posedge ref_clk_i);
      n++;
    end
    if (n >= 200) hang("busy release");
  endtask
  task automatic rb(input logic [31:0] e);
    rd(`APC_ADDR_RB_LO, {17'h0, e[15:0]});
    rd(`APC_ADDR_RB_HI, {17'h0, e[31:16]});
  endtask
  task automatic both(input logic [1:0] ax, input logic [31:0] e);
    cmd(`APC_OP_RD_CPOS, ax);
    rb(e);
    cmd(`APC_OP_RD_FPOS, ax);
    rb(e);
  endtask
  task automatic setpos(input logic [1:0] ax, input logic [31:0] d);
    apb(1'b1, `APC_ADDR_DATA, d);
    cmd(`APC_OP_WR_CPOS, ax);
    cmd(`APC_OP_WR_FPOS, ax);
  endtask
  task automatic move(input logic [3:0] m, input logic d, input int k);
    @(posedge ref_clk_i);
    run <= m;
    dir <= {4{d}};
    repeat (2 * k) @(posedge ref_clk_i);
    run <= 4'h0;
    repeat (4) @(posedge ref_clk_i);
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h0279));
    repeat (10) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    rd(`APC_ADDR_CFG, 33'h0);
    rd(`APC_ADDR_IRQ_MASK, 33'h0);
    apb(1'b1, 8'h20, 32'hffff_ffff);
    rd(8'h20, {1'b1, 32'h0});
    v = $urandom;
    apb(1'b1, `APC_ADDR_DATA, v);
    rd(`APC_ADDR_DATA, {1'b0, v});
    rd(`APC_ADDR_CMD, 33'h0);
    $display("test registers done");
    tbl = '{32'h7fff_ffff, 32'h8000_0000, $urandom, 32'h0};
    for (int a = 0; a < 4; a++) begin
      setpos(2'(a), tbl[a]);
      both(2'(a), tbl[a]);
    end
    $display("test position access done");
    // mixed encoder modes: even axes quadrature, odd axes up/down
    quad <= 4'h5;
    apb(1'b1, `APC_ADDR_CFG, 32'h0000_0005);
    for (int a = 0; a < 4; a++) setpos(2'(a), 32'h1);
    move(4'hf, 1'b1, 10);
    move(4'hf, 1'b0, 14);
    for (int a = 0; a < 4; a++) both(2'(a), 32'hffff_fffd);
    $display("test counting done");
    cmd(`APC_OP_RD_SPEED, 2'h2);
    rb(32'h0);
    cmd(`APC_OP_RD_RATE, 2'h2);
    rb(32'h0);
    run <= 4'h4;
    dir <= 4'hf;
    cmd(`APC_OP_RD_SPEED, 2'h2);
    run <= 4'h0;
    repeat (3) @(posedge ref_clk_i);
    rb(SPD + 32'h2);
    run <= 4'h4;
    cmd(`APC_OP_RD_RATE, 2'h2);
    run <= 4'h0;
    repeat (3) @(posedge ref_clk_i);
    rb(RAT + 32'h2);
    $display("test speed readback done");
    apb(1'b1, `APC_ADDR_DATA, 32'h5);
    cmd(`APC_OP_WR_CMPP, 2'h3);
    apb(1'b1, `APC_ADDR_DATA, 32'hffff_fffb);
    cmd(`APC_OP_WR_CMPM, 2'h3);
    apb(1'b1, `APC_ADDR_IRQ_STS, 32'h0000_01ff);
    apb(1'b1, `APC_ADDR_IRQ_MASK, 32'h0000_0008);
    check("limit_pos", {32'h0, lim_p[3]}, 33'h0);
    check("irq idle", {32'h0, irq}, 33'h0);
    move(4'h8, 1'b1, 8);
    check("limit_pos", {32'h0, lim_p[3]}, 33'h1);
    check("limit_neg", {32'h0, lim_n[3]}, 33'h0);
    check("irq raised", {32'h0, irq}, 33'h1);
    rd(`APC_ADDR_IRQ_STS, 33'h008);
    apb(1'b1, `APC_ADDR_IRQ_MASK, 32'h0);
    repeat (2) @(posedge ref_clk_i);
    check("irq masked", {32'h0, irq}, 33'h0);
    apb(1'b1, `APC_ADDR_IRQ_STS, 32'h0000_0008);
    rd(`APC_ADDR_IRQ_STS, 33'h0);
    apb(1'b1, `APC_ADDR_DATA, 32'h0);
    cmd(`APC_OP_WR_FPOS, 2'h3);
    check("limit src cmd", {32'h0, lim_p[3]}, 33'h1);
    apb(1'b1, `APC_ADDR_CFG, 32'h0000_0085);
    repeat (3) @(posedge ref_clk_i);
    check("limit src fb", {32'h0, lim_p[3]}, 33'h0);
    apb(1'b1, `APC_ADDR_DATA, 32'hffff_fffb);
    cmd(`APC_OP_WR_FPOS, 2'h3);
    check("limit_neg fb", {32'h0, lim_n[3]}, 33'h1);
    $display("test limits done");
    apb(1'b1, `APC_ADDR_CFG, 32'h0000_0205);
    apb(1'b1, `APC_ADDR_DATA, 32'h3);
    cmd(`APC_OP_WR_CMPP, 2'h1);
    setpos(2'h1, 32'h2);
    move(4'h2, 1'b1, 3);
    both(2'h1, 32'h1);
    check("wrap limit_pos", {32'h0, lim_p[1]}, 33'h0);
    check("wrap limit_neg", {32'h0, lim_n[1]}, 33'h0);
    move(4'h2, 1'b0, 2);
    both(2'h1, 32'h3);
    $display("test wrap done");
    apb(1'b1, `APC_ADDR_CMD, 32'h0000_8000);
    repeat (3) @(posedge ref_clk_i);
    check("soft reset", {32'h0, creset}, 33'h1);
    check("busy in reset", {32'h0, busy_n}, 33'h0);
    // a command is lost while the soft reset runs, so wait it out first
    for (int n = 0; n < 200 && busy_n !== 1'b1; n++) @(posedge ref_clk_i);
    if (busy_n !== 1'b1) hang("soft reset release");
    cmd(`APC_OP_RD_CPOS, 2'h1);
    rb(32'h0);
    rd(`APC_ADDR_CFG, 33'h0);
    $display("test soft reset done");
    print_verdict();
  end
endmodule
`default_nettype wire
